// *** rtcc_regs.sv ***
// rtcc_regs: control and status register group of the rtc, apb slave.
// assumes: events come from clock-core logic on pclk; apb master on pclk.
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - indices 00h to 04h form the control and status group
// - unused bit positions always read back as zero
// - mode bit 7 selects external clock test mode
// - clock source runs while the stop bit is zero
// - hundredths disable stops that counter and forces it to 00h
// - override sequence accepted only while mode bit 3 is one; resets to one
// - hour format bit: zero gives 24-hour, one gives 12-hour
// - enabled minute or second tick raises interrupt and sets flag bit 7
// - watchdog interrupt sets flag bit 6; software cannot clear it
// - alarm trigger sets the alarm flag, bit 4
// - alarm flag interrupts only while alarm enable bit 1 is one
// - periodic, alarm and switch-over interrupts stay until flag cleared
// - power bits 7 to 5 select the power management behaviour
// - timestamp taken at switch-over only while power bit 4 is one
// - switch-over to backup supply sets power bit 3
// - battery low flag follows battery state; software cannot clear it
// - switch-over flag interrupts only while bit 1 is one
// - battery low flag interrupts only while bit 0 is one
module rtcc_regs #(
   parameter int ADDR_W = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire rtcc_pkg::rtcc_event_t events,
   output rtcc_pkg::rtcc_ctrl_t ctrl,
   output rtcc_pkg::rtcc_irq_t irq
);

   // software-owned storage
   logic [7:0] mode_reg;
   logic aie_reg;
   logic [2:0] psel_reg;
   logic tse_reg;
   logic bie_reg;
   logic battery_low_irq_enable_reg;

   // hardware-owned status
   logic per_flag;
   logic alm_flag;
   logic swf_flag;
   logic wdt_reg;
   logic blf_reg;

   // bus response storage
   logic [31:0] prdata_reg;
   logic pslverr_reg;

   // outputs driven from flops
   rtcc_pkg::rtcc_irq_t irq_reg;
   rtcc_pkg::rtcc_irq_t irq_next;
   logic clock_run_reg;

   // bus decode
   logic sample;
   logic commit;
   logic addr_ok;
   logic [2:0] idx;
   logic wr_go;
   logic wr_mode;
   logic wr_flag;
   logic wr_pwr;
   logic [7:0] wbyte;
   logic [7:0] rd_byte;

   // event qualification
   logic per_set;
   logic clr_per;
   logic clr_alm;
   logic clr_swf;

   // handshake: answer one cycle into the access phase
   rtcc_apb_hs u_hs (
      .pclk(pclk),
      .presetn(presetn),
      .psel(psel),
      .penable(penable),
      .pready(pready),
      .sample(sample),
      .commit(commit)
   );

   // word-aligned decode; anything past index 04h is refused
   always_comb begin
      idx = 3'h0;
      addr_ok = 1'b0;
      if (paddr[1:0] == 2'b00 && (paddr >> 2) <= ADDR_W'(rtcc_pkg::IDX_LAST)) begin
         idx = 3'(paddr >> 2);
         addr_ok = 1'b1;
      end
   end

   // writes land at the completing edge only
   assign wr_go = commit & pwrite & addr_ok;
   assign wr_mode = wr_go & (idx == rtcc_pkg::IDX_MODE);
   assign wr_flag = wr_go & (idx == rtcc_pkg::IDX_FLAG);
   assign wr_pwr = wr_go & (idx == rtcc_pkg::IDX_PWR);
   assign wbyte = pwdata[7:0];

   // mode register, full byte writable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_reg <= rtcc_pkg::MODE_RST;
      end else if (wr_mode) begin
         mode_reg <= wbyte;
      end
   end

   // alarm enable; other bits of the flag byte are flags or unused
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         aie_reg <= rtcc_pkg::FLAG_RST[rtcc_pkg::FLAG_AIE];
      end else if (wr_flag) begin
         aie_reg <= wbyte[rtcc_pkg::FLAG_AIE];
      end
   end

   // power selector, timestamp and battery interrupt enables
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         psel_reg <= rtcc_pkg::PWR_RST[rtcc_pkg::PWR_SEL_HI:rtcc_pkg::PWR_SEL_LO];
         tse_reg <= rtcc_pkg::PWR_RST[rtcc_pkg::PWR_TSE];
         bie_reg <= rtcc_pkg::PWR_RST[rtcc_pkg::PWR_BIE];
         battery_low_irq_enable_reg <= rtcc_pkg::PWR_RST[rtcc_pkg::PWR_BATTERY_LOW_IRQ_ENABLE];
      end else if (wr_pwr) begin
         psel_reg <= wbyte[rtcc_pkg::PWR_SEL_HI:rtcc_pkg::PWR_SEL_LO];
         tse_reg <= wbyte[rtcc_pkg::PWR_TSE];
         bie_reg <= wbyte[rtcc_pkg::PWR_BIE];
         battery_low_irq_enable_reg <= wbyte[rtcc_pkg::PWR_BATTERY_LOW_IRQ_ENABLE];
      end
   end

   // periodic event counts only if its own enable is set
   assign per_set = (events.minute_tick & mode_reg[rtcc_pkg::MODE_MI]) |
                    (events.second_tick & mode_reg[rtcc_pkg::MODE_SI]);

   // zero written clears, one written leaves the flag alone
   assign clr_per = wr_flag & ~wbyte[rtcc_pkg::FLAG_PER];
   assign clr_alm = wr_flag & ~wbyte[rtcc_pkg::FLAG_ALM];
   assign clr_swf = wr_pwr & ~wbyte[rtcc_pkg::PWR_SWF];

   // periodic flag
   rtcc_sticky u_per (
      .pclk(pclk),
      .presetn(presetn),
      .set(per_set),
      .clr(clr_per),
      .flag_reg(per_flag)
   );

   // alarm flag, set regardless of its enable
   rtcc_sticky u_alm (
      .pclk(pclk),
      .presetn(presetn),
      .set(events.alarm_event),
      .clr(clr_alm),
      .flag_reg(alm_flag)
   );

   // switch-over flag
   rtcc_sticky u_swf (
      .pclk(pclk),
      .presetn(presetn),
      .set(events.switchover_event),
      .clr(clr_swf),
      .flag_reg(swf_flag)
   );

   // watchdog flag: only the watchdog itself may drop it, bus writes cannot
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wdt_reg <= 1'b0;
      end else if (events.watchdog_event) begin
         wdt_reg <= 1'b1;
      end else if (events.watchdog_clear) begin
         wdt_reg <= 1'b0;
      end
   end

   // battery low mirrors the detector; clears itself on replacement
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         blf_reg <= 1'b0;
      end else begin
         blf_reg <= events.battery_low;
      end
   end

   // clock source gate, registered so the core sees a clean level
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clock_run_reg <= ~rtcc_pkg::MODE_RST[rtcc_pkg::MODE_STOP];
      end else if (wr_mode) begin
         clock_run_reg <= ~wbyte[rtcc_pkg::MODE_STOP];
      end
   end

   // interrupt levels and strobes, next values
   always_comb begin
      irq_next = '0;
      irq_next.periodic_irq = per_flag;
      irq_next.watchdog_irq = wdt_reg;
      irq_next.alarm_irq = alm_flag & aie_reg;
      irq_next.switchover_irq = swf_flag & bie_reg;
      irq_next.battery_low_irq = blf_reg & battery_low_irq_enable_reg;
      irq_next.timestamp_capture = events.switchover_event & tse_reg;
      irq_next.override_accept = events.override_seq &
                                 mode_reg[rtcc_pkg::MODE_OVRD];
   end

   // one register stage keeps every output flop-driven
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_reg <= '0;
      end else begin
         irq_reg <= irq_next;
      end
   end

   // read mux; unused bits are constant zero, not stored
   always_comb begin
      rd_byte = 8'h00;
      unique case (idx)
         rtcc_pkg::IDX_MODE: begin
            rd_byte = mode_reg;
         end
         rtcc_pkg::IDX_FLAG: begin
            rd_byte[rtcc_pkg::FLAG_PER] = per_flag;
            rd_byte[rtcc_pkg::FLAG_WDT] = wdt_reg;
            rd_byte[rtcc_pkg::FLAG_ALM] = alm_flag;
            rd_byte[rtcc_pkg::FLAG_AIE] = aie_reg;
         end
         rtcc_pkg::IDX_PWR: begin
            rd_byte[rtcc_pkg::PWR_SEL_HI:rtcc_pkg::PWR_SEL_LO] = psel_reg;
            rd_byte[rtcc_pkg::PWR_TSE] = tse_reg;
            rd_byte[rtcc_pkg::PWR_SWF] = swf_flag;
            rd_byte[rtcc_pkg::PWR_BLF] = blf_reg;
            rd_byte[rtcc_pkg::PWR_BIE] = bie_reg;
            rd_byte[rtcc_pkg::PWR_BATTERY_LOW_IRQ_ENABLE] = battery_low_irq_enable_reg;
         end
         default: begin
            // timestamp group is kept elsewhere; reads zero here
            rd_byte = 8'h00;
         end
      endcase
   end

   // response loaded on the first access cycle; the error flop lives only while
   // pready stands, so the error output needs no gate behind the flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= 32'h0000_0000;
         pslverr_reg <= 1'b0;
      end else if (sample) begin
         prdata_reg <= (pwrite || !addr_ok) ? 32'h0000_0000 : {24'h00_0000, rd_byte};
         pslverr_reg <= ~addr_ok;
      end else begin
         pslverr_reg <= 1'b0;
      end
   end

   assign prdata = prdata_reg;
   assign pslverr = pslverr_reg;
   assign irq = irq_reg;

   // settings to the clock core straight from storage
   always_comb begin
      ctrl.clock_test_mode = mode_reg[rtcc_pkg::MODE_TEST];
      ctrl.temp_comp_disable = mode_reg[rtcc_pkg::MODE_TCDIS];
      ctrl.clock_run = clock_run_reg;
      ctrl.hundredths_disable = mode_reg[rtcc_pkg::MODE_HDIS];
      ctrl.reset_override_enable = mode_reg[rtcc_pkg::MODE_OVRD];
      ctrl.hour_12_mode = mode_reg[rtcc_pkg::MODE_H12];
      ctrl.minute_irq_enable = mode_reg[rtcc_pkg::MODE_MI];
      ctrl.second_irq_enable = mode_reg[rtcc_pkg::MODE_SI];
      ctrl.power_mgmt_select = psel_reg;
      ctrl.switchover_timestamp_enable = tse_reg;
   end

endmodule
`default_nettype wire

// *** rtcc_pkg.sv ***
// rtcc_pkg: offsets, field positions, reset values and carriers of the
// rtc control/status register bank.
// assumes: used by the regs, handshake and checker files through package-scoped names.
package rtcc_pkg;

   // register indices; byte address is four times the index
   localparam logic [2:0] IDX_MODE = 3'h0;
   localparam logic [2:0] IDX_FLAG = 3'h1;
   localparam logic [2:0] IDX_PWR = 3'h2;
   localparam logic [2:0] IDX_TS_FLAG = 3'h3;
   localparam logic [2:0] IDX_TS_EN = 3'h4;
   localparam logic [2:0] IDX_LAST = 3'h4;

   // control_mode_register fields
   localparam int MODE_TEST = 7;
   localparam int MODE_TCDIS = 6;
   localparam int MODE_STOP = 5;
   localparam int MODE_HDIS = 4;
   localparam int MODE_OVRD = 3;
   localparam int MODE_H12 = 2;
   localparam int MODE_MI = 1;
   localparam int MODE_SI = 0;

   // interrupt_flag_alarm_register fields
   localparam int FLAG_PER = 7;
   localparam int FLAG_WDT = 6;
   localparam int FLAG_ALM = 4;
   localparam int FLAG_AIE = 1;

   // battery_power_register fields
   localparam int PWR_SEL_HI = 7;
   localparam int PWR_SEL_LO = 5;
   localparam int PWR_TSE = 4;
   localparam int PWR_SWF = 3;
   localparam int PWR_BLF = 2;
   localparam int PWR_BIE = 1;
   localparam int PWR_BATTERY_LOW_IRQ_ENABLE = 0;

   // reset values
   localparam logic [7:0] MODE_RST = 8'h08;
   localparam logic [7:0] FLAG_RST = 8'h00;
   localparam logic [7:0] PWR_RST = 8'hE0;

   // events from the rest of the clock core, same clock domain
   typedef struct packed {
      logic minute_tick;
      logic second_tick;
      logic watchdog_event;
      logic watchdog_clear;
      logic alarm_event;
      logic switchover_event;
      logic battery_low;
      logic override_seq;
   } rtcc_event_t;

   // settings steering the clock core
   typedef struct packed {
      logic clock_test_mode;
      logic temp_comp_disable;
      logic clock_run;
      logic hundredths_disable;
      logic reset_override_enable;
      logic hour_12_mode;
      logic minute_irq_enable;
      logic second_irq_enable;
      logic [2:0] power_mgmt_select;
      logic switchover_timestamp_enable;
   } rtcc_ctrl_t;

   // interrupt requests and strobes
   typedef struct packed {
      logic periodic_irq;
      logic watchdog_irq;
      logic alarm_irq;
      logic switchover_irq;
      logic battery_low_irq;
      logic timestamp_capture;
      logic override_accept;
   } rtcc_irq_t;

   // apb handshake states
   typedef enum logic [1:0] {
      RTCC_IDLE = 2'b01,
      RTCC_DONE = 2'b10
   } rtcc_apb_state_t;

endpackage

// *** rtcc_sticky.sv ***
// rtcc_sticky: one sticky event flag, set by hardware, cleared by software.
// assumes: set and clr are single-clock pulses on pclk.
`timescale 1ns/10ps
`default_nettype none
module rtcc_sticky (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic set,
   input wire logic clr,
   output logic flag_reg
);

   // set beats clear so an event in the clearing cycle is kept
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_reg <= 1'b0;
      end else if (set) begin
         flag_reg <= 1'b1;
      end else if (clr) begin
         flag_reg <= 1'b0;
      end
   end

endmodule
`default_nettype wire

// *** rtcc_apb_hs.sv ***
// rtcc_apb_hs: apb access-phase handshake, one wait state per transfer.
// assumes: an apb master on pclk holding the request until pready.
`timescale 1ns/10ps
`default_nettype none
module rtcc_apb_hs (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   output logic pready,
   output logic sample,
   output logic commit
);

   rtcc_pkg::rtcc_apb_state_t state_reg;

   // first access cycle loads read data, second completes it
   assign sample = psel & penable & (state_reg == rtcc_pkg::RTCC_IDLE);
   assign commit = psel & penable & (state_reg == rtcc_pkg::RTCC_DONE);

   // handshake state and the registered ready
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= rtcc_pkg::RTCC_IDLE;
         pready <= 1'b0;
      end else begin
         unique case (state_reg)
            rtcc_pkg::RTCC_IDLE: begin
               if (sample) begin
                  state_reg <= rtcc_pkg::RTCC_DONE;
                  pready <= 1'b1;
               end
            end
            rtcc_pkg::RTCC_DONE: begin
               state_reg <= rtcc_pkg::RTCC_IDLE;
               pready <= 1'b0;
            end
            default: begin
               state_reg <= rtcc_pkg::RTCC_IDLE;
               pready <= 1'b0;
            end
         endcase
      end
   end

endmodule
`default_nettype wire

// *** rtcc_regs_chk.sv ***
// rtcc_regs_chk: port-level assertions for the rtc control/status bank.
// assumes: bound to rtcc_regs; everything on the one pclk domain.
`timescale 1ns/10ps
`default_nettype none
module rtcc_regs_chk #(
   parameter int ADDR_W = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire rtcc_pkg::rtcc_event_t events,
   input wire rtcc_pkg::rtcc_ctrl_t ctrl,
   input wire rtcc_pkg::rtcc_irq_t irq
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // bus answer and address map
   ready_wait_a: assert property (
      $rose(penable) && psel |-> !pready ##1 pready) else $error("pready not in 2nd access");
   map_err_a: assert property (
      pready |-> pslverr == (paddr[ADDR_W-1:2] > 4 || paddr[1:0] != 2'h0))
      else $error("pslverr does not match address map");
   zero_bits_a: assert property (
      pready |-> prdata[31:8] == 24'h00_0000 && (paddr != 8'h04 || (prdata[7:0] & 8'h2d) == 8'h00))
      else $error("unused bits read nonzero");
   // mode settings follow the written byte one cycle later
   test_mode_a: assert property (
      pready && pwrite && paddr == 8'h00 |=> ctrl.clock_test_mode == $past(pwdata[7])
      && ctrl.hour_12_mode == $past(pwdata[2])) else $error("mode outputs wrong");
   clock_run_a: assert property (
      pready && pwrite && paddr == 8'h00 |=> ctrl.clock_run == !$past(pwdata[5])
      && ctrl.hundredths_disable == $past(pwdata[4])) else $error("run or hdis wrong");
   // event strobes gated by their enables, then irq set and hold checks
   override_a: assert property (
      events.override_seq |=> irq.override_accept == $past(ctrl.reset_override_enable))
      else $error("override accept wrong");
   stamp_a: assert property (
      events.switchover_event |=> irq.timestamp_capture == $past(ctrl.switchover_timestamp_enable))
      else $error("timestamp strobe wrong");
   periodic_a: assert property (
      events.minute_tick && ctrl.minute_irq_enable |-> ##2 irq.periodic_irq)
      else $error("periodic irq missing");
   wdt_set_a: assert property (
      events.watchdog_event |-> ##2 irq.watchdog_irq) else $error("watchdog irq missing");
   wdt_hold_a: assert property (
      $fell(irq.watchdog_irq) |-> $past(events.watchdog_clear, 2))
      else $error("watchdog irq dropped without clear");
   alarm_hold_a: assert property (
      $fell(irq.alarm_irq) |-> $past(pready, 2) && $past(pwrite, 2) && $past(paddr, 2) == 8'h04)
      else $error("alarm irq dropped without write");
   batt_low_a: assert property (
      irq.battery_low_irq |-> $past(events.battery_low, 2)) else $error("battery irq w/o low");
endmodule
bind rtcc_regs rtcc_regs_chk #(.ADDR_W(ADDR_W)) chk_i (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .events(events), .ctrl(ctrl),
   .irq(irq));
`default_nettype wire

// *** rtcc_host.sv ***
// rtcc_host: host-side apb master model with one transfer task.
// assumes: called from a process that may be at any point of the cycle.
`timescale 1ns/10ps
`default_nettype none
module rtcc_host (
   input wire logic pclk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   // idle bus at time zero
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
   end
   // request held until pready is sampled high or 50 cycles pass; released bus shows inverted data
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] rd, output logic err, output logic to);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      to = (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~a;
      pwdata <= ~d;
   endtask
endmodule
`default_nettype wire

// *** tb_top.sv ***
// tb_top: register-level tests of the rtc control/status bank.
// assumes: rtcc_host drives apb; events are driven here in the clock core's place.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdat;
   rtcc_pkg::rtcc_event_t ev;
   rtcc_pkg::rtcc_ctrl_t ctrl;
   rtcc_pkg::rtcc_irq_t irq;
   int n_errors, cmp_count;
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   rtcc_regs rtcc_regs_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .events(ev), .ctrl(ctrl), .irq(irq));
   rtcc_host rtcc_host_i (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   task automatic end_of_test();
      $display("compares %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk_reg(input string n, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", n, exp, got);
      end
   endtask
   task automatic chk_bit(input string n, input logic exp, input logic got);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value %s expected %b seen %b", n, exp, got);
      end
   endtask
   // a hung transfer ends the run at once
   task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d);
      logic t;
      rtcc_host_i.xfer(wr, a, d, rdat, rerr, t);
      if (t) begin
         chk_bit("pready", 1'b1, 1'b0);
         end_of_test();
      end
   endtask
   // write, then let register and irq flops land
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      acc(1'b1, a, d);
      repeat (2) @(posedge pclk);
   endtask
   task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] exp);
      acc(1'b0, a, 32'h0000_0000);
      chk_reg(n, exp, rdat);
      chk_bit("pslverr", (a > 8'h10) || (a[1:0] != 2'h0), rerr);
   endtask
   // one-cycle event pulse; mask bits follow the struct's field order
   task automatic pulse(input logic [7:0] m);
      @(posedge pclk);
      ev <= ev | m;
      @(posedge pclk);
      ev <= ev & ~m;
      repeat (2) @(posedge pclk);
   endtask
   task automatic low(input logic v);
      @(posedge pclk);
      ev.battery_low <= v;
      repeat (3) @(posedge pclk);
   endtask
   initial begin
      presetn = 1'b0;
      ev = '0;
      n_errors = 0;
      cmp_count = 0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rchk("mode", 8'h00, 32'h0000_0008);
      rchk("flag", 8'h04, 32'h0000_0000);
      rchk("pwr", 8'h08, 32'h0000_00e0);
      rchk("ts flag", 8'h0c, 32'h0000_0000);
      rchk("ts en", 8'h10, 32'h0000_0000);
      rchk("unmapped", 8'h14, 32'h0000_0000);
      rchk("misaligned", 8'h01, 32'h0000_0000);
      pulse(8'h01);
      $display("test map done");
      wr(8'h00, 32'hffff_ffff);
      chk_bit("test mode", 1'b1, ctrl.clock_test_mode);
      chk_bit("clock run", 1'b0, ctrl.clock_run);
      chk_bit("hdis", 1'b1, ctrl.hundredths_disable);
      chk_bit("h12", 1'b1, ctrl.hour_12_mode);
      chk_bit("temp_comp_disable", 1'b1, ctrl.temp_comp_disable);
      chk_bit("ovrd en", 1'b1, ctrl.reset_override_enable);
      chk_bit("min en", 1'b1, ctrl.minute_irq_enable);
      chk_bit("sec en", 1'b1, ctrl.second_irq_enable);
      rchk("mode", 8'h00, 32'h0000_00ff);
      wr(8'h00, 32'h0000_0002);
      chk_bit("clock run", 1'b1, ctrl.clock_run);
      pulse(8'h01);
      $display("test mode done");
      pulse(8'h80);
      rchk("flag", 8'h04, 32'h0000_0080);
      chk_bit("periodic", 1'b1, irq.periodic_irq);
      wr(8'h04, 32'h0000_0000);
      pulse(8'h40);
      rchk("flag", 8'h04, 32'h0000_0000);
      wr(8'h04, 32'h0000_00ff);
      rchk("flag", 8'h04, 32'h0000_0002);
      pulse(8'h08);
      rchk("flag", 8'h04, 32'h0000_0012);
      chk_bit("alarm irq", 1'b1, irq.alarm_irq);
      wr(8'h04, 32'h0000_0012);
      chk_bit("alarm irq", 1'b1, irq.alarm_irq);
      wr(8'h04, 32'h0000_0002);
      rchk("flag", 8'h04, 32'h0000_0002);
      pulse(8'h20);
      wr(8'h04, 32'h0000_0002);
      rchk("flag", 8'h04, 32'h0000_0042);
      pulse(8'h10);
      $display("test flags done");
      wr(8'h08, 32'h0000_00ff);
      rchk("pwr", 8'h08, 32'h0000_00f3);
      chk_reg("pwr sel", 32'h0000_0007, {29'h0000_0000, ctrl.power_mgmt_select});
      chk_bit("ts en", 1'b1, ctrl.switchover_timestamp_enable);
      pulse(8'h04);
      rchk("pwr", 8'h08, 32'h0000_00fb);
      chk_bit("switch irq", 1'b1, irq.switchover_irq);
      low(1'b1);
      chk_bit("low irq", 1'b1, irq.battery_low_irq);
      wr(8'h08, 32'h0000_0000);
      rchk("pwr", 8'h08, 32'h0000_0004);
      low(1'b0);
      rchk("pwr", 8'h08, 32'h0000_0000);
      $display("test power done");
      @(posedge pclk);
      presetn <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b1;
      rchk("mode", 8'h00, 32'h0000_0008);
      $display("test reset done");
      end_of_test();
   end
endmodule
`default_nettype wire
